// file: logic/tmc_consts.svh
// Purpose: addresses, field positions and reset values of the timer unit
// Assumes: 32-bit apb data, one register per aligned word
// Notes: definitions only
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
`define TMC_A_CTRL      8'h00
`define TMC_A_STAT      8'h04
`define TMC_A_MASK      8'h08
`define TMC_A_CNT       8'h0c
`define TMC_A_PER       8'h10
`define TMC_A_PERACT    8'h14
`define TMC_A_CC0       8'h18
`define TMC_F_CLK       2:0
`define TMC_F_WG        5:4
`define TMC_F_CAP       7:6
`define TMC_B_DIR       8
`define TMC_B_SPLIT     9
`define TMC_B_CASC      10
`define TMC_B_EVDIR     11
`define TMC_B_SYNC      12
`define TMC_B_CCEN      16
`define TMC_S_OVF       0
`define TMC_S_ERR       1
`define TMC_S_CC        2
`define TMC_PER_RST     16'hffff
`define TMC_ZERO16      16'h0000
`define TMC_ZERO32      32'h0000_0000
`define TMC_PM_DIV1     10'h000
`define TMC_PM_DIV2     10'h001
`define TMC_PM_DIV8     10'h007
`define TMC_PM_DIV64    10'h03f
`define TMC_PM_DIV1024  10'h3ff
`endif

// file: logic/tmc_pkg.sv
// Purpose: shared types of the timer unit
// Assumes: nothing
// Notes: encodings match the control register fields
package tmc_pkg;
	typedef enum logic [2:0] {
		CLK_OFF = 3'b000, CLK_DIV1 = 3'b001, CLK_DIV2 = 3'b010, CLK_DIV8 = 3'b011,
		CLK_DIV64 = 3'b100, CLK_DIV1024 = 3'b101, CLK_EVENT = 3'b110, CLK_QUAD = 3'b111
	} tmc_clk_type;
	typedef enum logic [1:0] {
		WG_NORMAL = 2'b00, WG_FREQ = 2'b01, WG_SS = 2'b10, WG_DS = 2'b11
	} tmc_wg_type;
	typedef enum logic [1:0] {
		CAP_OFF = 2'b00, CAP_INPUT = 2'b01, CAP_FREQ = 2'b10, CAP_PW = 2'b11
	} tmc_cap_type;
	typedef enum logic {SLOPE_UP = 1'b0, SLOPE_DOWN = 1'b1} tmc_slope_type;
endpackage : tmc_pkg

// file: logic/tmc_filter.sv
// Purpose: noise canceller for capture and quadrature inputs
// Assumes: inputs synchronous to pclk
// Notes: output follows only after LEN equal samples
`timescale 1ns/1ps
`default_nettype none
module tmc_filter #(
	parameter int W   = 6,
	parameter int LEN = 3
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [LEN-1:0] hist_q [W];
	logic [W-1:0]   out_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < W; i++)
				hist_q[i] <= '0;
			out_q <= '0;
		end
		else
		begin
			for (int i = 0; i < W; i++)
			begin
				hist_q[i] <= {hist_q[i][LEN-2:0], din[i]};
				if (&hist_q[i])
					out_q[i] <= 1'b1;
				else if (~|hist_q[i])
					out_q[i] <= 1'b0;
			end
		end
	end

	assign dout = out_q;
endmodule : tmc_filter
`default_nettype wire

// file: logic/tmc_timer.sv
// Purpose: 16-bit timer unit with compare/capture channels behind apb
// Assumes: event inputs are one-cycle pulses synchronous to pclk
// Notes: NUM_CH=4 is the full variant, NUM_CH=2 the reduced one
// Function
// - the base counter is 16 bits and counts clock ticks or events.
// - the counter has a programmable period and selectable direction.
// - the full variant has four channels, the reduced one two.
// - channels work either all as compare or all as capture.
// - two units chain into a 32-bit counter, with 32-bit capture.
// - only the full variant splits into two 8-bit counters of four compares each.
// - the count source is the prescaled peripheral clock or event inputs.
// - event inputs steer direction, trigger capture or restart the counter.
// - the period is double buffered and changes only at an update.
// - every channel value is double buffered.
// - waveforms are frequency, single-slope pwm and dual-slope pwm.
// - capture has a noise filter and input, frequency and pulse-width modes.
// - overflow and error raise interrupt events.
// - each channel raises an event on compare match or capture.
// - overflow and channel events issue dma triggers.
// - event inputs allow quadrature decoding and count/direction control.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_timer #(
	parameter int NUM_CH  = 4,
	parameter int FLT_LEN = 3
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                ev_count,
	input  wire logic                ev_dir,
	input  wire logic                ev_restart,
	input  wire logic                casc_in,
	input  wire logic [NUM_CH-1:0]   cap_in,
	input  wire logic                quad_a,
	input  wire logic                quad_b,
	output logic                     irq,
	output logic                     ovf_evt,
	output logic                     dma_ovf,
	output logic      [NUM_CH-1:0]   dma_cc,
	output logic      [2*NUM_CH-1:0] wo
);
	import tmc_pkg::*;
	localparam int SW = NUM_CH + 2;

	logic [31:0]     ctrl_q, prdata_q;
	logic [SW-1:0]   st_q, st_d, mask_q, st_set;
	logic [15:0]     cnt_q, cnt_d, per_act_q, per_buf_q;
	logic            per_bv_q, pready_q, pslverr_q, irq_q, ovf_evt_q, dma_ovf_q;
	logic [15:0]     cc_act_q [NUM_CH];
	logic [15:0]     cc_buf_q [NUM_CH];
	logic [NUM_CH-1:0] cc_bv_q, cc_en, cap_ev, cmp_hit, dma_cc_q, cap_rise, cap_fall;
	logic [2*NUM_CH-1:0] wo_q;
	logic [9:0]      pre_q, pre_m;
	logic [SW-1:0]   flt, flt_q;
	tmc_slope_type   slope_q, slope_d;
	tmc_clk_type     clk_sel;
	tmc_wg_type      wg_mode;
	tmc_cap_type     cap_mode;
	logic            tick, cnt_up, ovf_hit, restart, split, casc, err_ev;
	logic            acc, wr, cnt_wr, is_cc, mapped;
	logic [7:0]      cc_off;
	logic [5:0]      cc_idx;
	logic [31:0]     rd_val;

	assign clk_sel  = tmc_clk_type'(ctrl_q[`TMC_F_CLK]);
	assign wg_mode  = tmc_wg_type'(ctrl_q[`TMC_F_WG]);
	assign cap_mode = tmc_cap_type'(ctrl_q[`TMC_F_CAP]);
	assign split    = ctrl_q[`TMC_B_SPLIT] && (NUM_CH == 4);
	assign casc     = ctrl_q[`TMC_B_CASC];
	assign cc_en    = ctrl_q[`TMC_B_CCEN +: NUM_CH];

	// apb decode
	assign acc    = psel && penable && pready_q;
	assign wr     = acc && pwrite;
	assign cc_off = paddr - `TMC_A_CC0;
	assign cc_idx = cc_off[7:2];
	// unaligned channel address is refused, so its write must not land
	assign is_cc  = (paddr >= `TMC_A_CC0) && (cc_idx < 6'(NUM_CH)) && (paddr[1:0] == 2'b00);
	assign cnt_wr = wr && (paddr == `TMC_A_CNT);

	always_comb
	begin
		mapped = (paddr[1:0] == 2'b00);
		rd_val = `TMC_ZERO32;
		case (paddr)
			`TMC_A_CTRL:   rd_val = ctrl_q;
			`TMC_A_STAT:   rd_val = 32'(st_q);
			`TMC_A_MASK:   rd_val = 32'(mask_q);
			`TMC_A_CNT:    rd_val = 32'(cnt_q);
			`TMC_A_PER:    rd_val = 32'(per_buf_q);
			`TMC_A_PERACT: rd_val = 32'(per_act_q);
			default:
			begin
				if (is_cc)
					rd_val = 32'(cc_act_q[cc_idx[1:0]]);
				else
					mapped = 1'b0;
			end
		endcase
	end

	// answer one cycle after setup: zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `TMC_ZERO32;
		end
		else
		begin
			pready_q  <= psel && !penable;
			pslverr_q <= psel && !penable && !mapped;
			if (psel && !penable)
				prdata_q <= pwrite ? `TMC_ZERO32 : rd_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `TMC_ZERO32;
			mask_q <= '0;
		end
		else if (wr && paddr == `TMC_A_CTRL)
			ctrl_q <= pwdata;
		else if (wr && paddr == `TMC_A_MASK)
			mask_q <= pwdata[SW-1:0];
	end

	// noise cancelling on capture and quadrature inputs
	tmc_filter #(.W(SW), .LEN(FLT_LEN)) u_flt (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({quad_b, quad_a, cap_in}),
		.dout    (flt)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flt_q <= '0;
			pre_q <= '0;
		end
		else
		begin
			flt_q <= flt;
			pre_q <= pre_q + 10'h001;
		end
	end

	assign cap_rise = flt[NUM_CH-1:0] & ~flt_q[NUM_CH-1:0];
	assign cap_fall = ~flt[NUM_CH-1:0] & flt_q[NUM_CH-1:0];

	always_comb
	begin
		case (clk_sel)
			CLK_DIV2:    pre_m = `TMC_PM_DIV2;
			CLK_DIV8:    pre_m = `TMC_PM_DIV8;
			CLK_DIV64:   pre_m = `TMC_PM_DIV64;
			CLK_DIV1024: pre_m = `TMC_PM_DIV1024;
			default:     pre_m = `TMC_PM_DIV1;
		endcase
	end

	// count source and direction
	always_comb
	begin
		tick   = 1'b0;
		cnt_up = !ctrl_q[`TMC_B_DIR];
		if (clk_sel == CLK_OFF)
			tick = 1'b0;
		else if (casc)
			tick = casc_in;
		else
		begin
			case (clk_sel)
				CLK_EVENT:
				begin
					tick = ev_count;
					if (ctrl_q[`TMC_B_EVDIR])
						cnt_up = !ev_dir;
				end
				CLK_QUAD:
				begin
					// a step on either phase; order of phases sets direction
					tick   = (flt[NUM_CH] ^ flt_q[NUM_CH]) | (flt[NUM_CH+1] ^ flt_q[NUM_CH+1]);
					cnt_up = flt_q[NUM_CH] ^ flt[NUM_CH+1];
				end
				default: tick = ((pre_q & pre_m) == pre_m);
			endcase
		end
	end

	// captures and restarts; frequency and pulse width use channel 0
	always_comb
	begin
		cap_ev = '0;
		for (int i = 0; i < NUM_CH; i++)
		begin
			case (cap_mode)
				CAP_INPUT: cap_ev[i] = cc_en[i] && cap_rise[i];
				CAP_FREQ:  cap_ev[i] = (i == 0) && cc_en[0] && cap_rise[0];
				CAP_PW:    cap_ev[i] = (i == 0) && cc_en[0] && cap_fall[0];
				default:   cap_ev[i] = 1'b0;
			endcase
		end
	end

	assign restart = (ctrl_q[`TMC_B_SYNC] && ev_restart)
		|| ((cap_mode == CAP_FREQ || cap_mode == CAP_PW) && cc_en[0] && cap_rise[0]);

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
			cmp_hit[i] = tick && (cap_mode == CAP_OFF) && cc_en[i]
				&& (split ? cnt_q[7:0] == cc_act_q[i][7:0] : cnt_q == cc_act_q[i]);
	end

	// base counter next value
	always_comb
	begin
		cnt_d   = cnt_q;
		slope_d = slope_q;
		ovf_hit = 1'b0;
		if (split && tick)
		begin
			// two 8-bit up counters; the low one owns overflow and updates
			if (cnt_q[7:0] >= per_act_q[7:0])
			begin
				cnt_d[7:0] = 8'h00;
				ovf_hit    = 1'b1;
			end
			else
				cnt_d[7:0] = cnt_q[7:0] + 8'h01;
			if (cnt_q[15:8] >= per_act_q[15:8])
				cnt_d[15:8] = 8'h00;
			else
				cnt_d[15:8] = cnt_q[15:8] + 8'h01;
		end
		else if (tick && wg_mode == WG_DS)
		begin
			if (slope_q == SLOPE_UP)
			begin
				if (cnt_q >= per_act_q)
				begin
					cnt_d   = cnt_q - 16'h0001;
					slope_d = SLOPE_DOWN;
				end
				else
					cnt_d = cnt_q + 16'h0001;
			end
			else if (cnt_q == `TMC_ZERO16)
			begin
				cnt_d   = 16'h0001;
				slope_d = SLOPE_UP;
				ovf_hit = 1'b1;
			end
			else
				cnt_d = cnt_q - 16'h0001;
		end
		else if (tick && cnt_up)
		begin
			if (cnt_q >= per_act_q)
			begin
				cnt_d   = `TMC_ZERO16;
				ovf_hit = 1'b1;
			end
			else
				cnt_d = cnt_q + 16'h0001;
		end
		else if (tick)
		begin
			if (cnt_q == `TMC_ZERO16)
			begin
				cnt_d   = per_act_q;
				ovf_hit = 1'b1;
			end
			else
				cnt_d = cnt_q - 16'h0001;
		end
		if (restart)
		begin
			cnt_d   = (cnt_up || wg_mode == WG_DS) ? `TMC_ZERO16 : per_act_q;
			slope_d = SLOPE_UP;
		end
		if (cnt_wr)
			cnt_d = pwdata[15:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q   <= `TMC_ZERO16;
			slope_q <= SLOPE_UP;
		end
		else
		begin
			cnt_q   <= cnt_d;
			slope_q <= slope_d;
		end
	end

	// period buffer; a write in the update cycle stays pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			per_act_q <= `TMC_PER_RST;
			per_buf_q <= `TMC_PER_RST;
			per_bv_q  <= 1'b0;
		end
		else
		begin
			if (ovf_hit && per_bv_q)
				per_act_q <= per_buf_q;
			if (wr && paddr == `TMC_A_PER)
			begin
				per_buf_q <= pwdata[15:0];
				per_bv_q  <= 1'b1;
			end
			else if (ovf_hit)
				per_bv_q <= 1'b0;
		end
	end

	// channel buffers and captures
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				cc_act_q[i] <= `TMC_ZERO16;
				cc_buf_q[i] <= `TMC_ZERO16;
			end
			cc_bv_q <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (cap_ev[i])
					cc_act_q[i] <= cnt_q;
				else if (ovf_hit && cc_bv_q[i] && cap_mode == CAP_OFF)
					cc_act_q[i] <= cc_buf_q[i];
				if (wr && is_cc && cc_idx == 6'(i))
				begin
					cc_buf_q[i] <= pwdata[15:0];
					cc_bv_q[i]  <= 1'b1;
				end
				else if (ovf_hit)
					cc_bv_q[i] <= 1'b0;
			end
		end
	end

	// waveform outputs; upper half is the split high counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wo_q <= '0;
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (split)
				begin
					wo_q[i]        <= cnt_d[7:0] < cc_act_q[i][7:0];
					wo_q[i+NUM_CH] <= cnt_d[15:8] < cc_act_q[i][15:8];
				end
				else
				begin
					wo_q[i+NUM_CH] <= 1'b0;
					case (wg_mode)
						WG_FREQ:   wo_q[i] <= wo_q[i] ^ cmp_hit[i];
						WG_SS:     wo_q[i] <= cc_en[i] && (cnt_d < cc_act_q[i]);
						WG_DS:     wo_q[i] <= cc_en[i] && (cnt_d < cc_act_q[i]);
						default:   wo_q[i] <= 1'b0;
					endcase
				end
			end
		end
	end

	// capture over a still-set channel flag is an error
	assign err_ev = |(cap_ev & st_q[`TMC_S_CC +: NUM_CH]);
	assign st_set = {cap_ev | cmp_hit, err_ev, ovf_hit};
	// set wins over a same-cycle write-one clear
	assign st_d   = (st_q & ~((wr && paddr == `TMC_A_STAT) ? pwdata[SW-1:0] : '0)) | st_set;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q      <= '0;
			irq_q     <= 1'b0;
			ovf_evt_q <= 1'b0;
			dma_ovf_q <= 1'b0;
			dma_cc_q  <= '0;
		end
		else
		begin
			st_q      <= st_d;
			irq_q     <= |(st_d & mask_q);
			ovf_evt_q <= ovf_hit;
			dma_ovf_q <= ovf_hit;
			dma_cc_q  <= cap_ev | cmp_hit;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;
	assign ovf_evt = ovf_evt_q;
	assign dma_ovf = dma_ovf_q;
	assign dma_cc  = dma_cc_q;
	assign wo      = wo_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_free;
		tick && !split && wg_mode != WG_DS && !restart && !cnt_wr;
	endsequence
	sequence s_up_mid;
		s_free ##0 cnt_up && cnt_q < per_act_q;
	endsequence
	sequence s_up_top;
		s_free ##0 cnt_up && cnt_q >= per_act_q;
	endsequence

	cnt_step_a: assert property (s_up_mid |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not step up");
	wrap_ovf_a: assert property (s_up_top |=> cnt_q == `TMC_ZERO16 && st_q[`TMC_S_OVF])
		else $error("counter did not wrap with overflow");
	down_reload_a: assert property (s_free ##0 !cnt_up && cnt_q == `TMC_ZERO16
		|=> cnt_q == $past(per_act_q))
		else $error("down count did not reload period");
	per_hold_a: assert property (!ovf_hit |=> $stable(per_act_q))
		else $error("active period changed outside update");
	per_load_a: assert property (ovf_hit && per_bv_q |=> per_act_q == $past(per_buf_q))
		else $error("buffered period not loaded");
	cc_load_a: assert property (ovf_hit && cc_bv_q[0] && cap_mode == CAP_OFF && !cap_ev[0]
		|=> cc_act_q[0] == $past(cc_buf_q[0]))
		else $error("channel buffer not loaded");
	cap_store_a: assert property (cap_ev[0] |=> cc_act_q[0] == $past(cnt_q)
		&& st_q[`TMC_S_CC])
		else $error("capture value or flag missing");
	mode_excl_a: assert property (cap_mode != CAP_OFF && cap_ev == '0 |=> dma_cc_q == '0)
		else $error("compare active in capture mode");
	irq_level_a: assert property (##1 irq_q == |(st_q & $past(mask_q)))
		else $error("interrupt does not follow masked status");
	dma_ovf_a: assert property (ovf_hit |=> dma_ovf_q && ovf_evt_q)
		else $error("overflow trigger missing");
	ds_turn_a: assert property (tick && wg_mode == WG_DS && !split && !restart && !cnt_wr
		&& slope_q == SLOPE_UP && cnt_q >= per_act_q |=> slope_q == SLOPE_DOWN)
		else $error("dual slope did not turn at top");
	apb_ready_a: assert property (psel && !penable |=> pready_q ##1 !pready_q || (psel && !penable))
		else $error("apb answer timing wrong");
endmodule : tmc_timer
`default_nettype wire

// file: dv/tmc_evsrc.sv
// Purpose: event channels and input pins that feed the timer unit
// Assumes: the bench calls the tasks, one at a time
// Notes: levels change just after a rising edge and hold past the filter
`timescale 1ns/1ps
`default_nettype none
module tmc_evsrc #(
	parameter int NUM_CH = 4
) (
	input  wire logic              pclk,
	output logic                   ev_count,
	output logic                   ev_dir,
	output logic                   ev_restart,
	output logic                   casc_in,
	output logic      [NUM_CH-1:0] cap_in,
	output logic                   quad_a,
	output logic                   quad_b
);
	initial
	begin
		ev_count = 1'b0;
		ev_dir = 1'b0;
		ev_restart = 1'b0;
		casc_in = 1'b0;
		cap_in = '0;
		quad_a = 1'b0;
		quad_b = 1'b0;
	end
	task pulses(input int n, input int gap);
		for (int i = 0; i < n; i++)
		begin
			@(posedge pclk);
			ev_count <= 1'b1;
			@(posedge pclk);
			ev_count <= 1'b0;
			repeat (gap) @(posedge pclk);
		end
	endtask : pulses
	// carries as from a lower unit's overflow output
	task carry(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge pclk);
			casc_in <= 1'b1;
			@(posedge pclk);
			casc_in <= 1'b0;
		end
	endtask : carry
	task set_dir(input logic v);
		@(posedge pclk);
		ev_dir <= v;
	endtask : set_dir
	task restart;
		@(posedge pclk);
		ev_restart <= 1'b1;
		@(posedge pclk);
		ev_restart <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : restart
	// held long enough for the noise filter to accept it
	task set_cap(input int i, input logic v);
		@(posedge pclk);
		cap_in[i] <= v;
		repeat (8) @(posedge pclk);
	endtask : set_cap
	// forward steps: b leads a
	task quad(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge pclk);
			if (quad_a == quad_b)
				quad_b <= ~quad_a;
			else
				quad_a <= quad_b;
			repeat (8) @(posedge pclk);
		end
	endtask : quad
endmodule : tmc_evsrc
`default_nettype wire

// file: dv/timer_counter16_cc_bench.sv
// Purpose: self-checking bench of the timer unit over apb
// Assumes: apb answers in one access cycle, xorshift seed 49
// Notes: expectations come from bench functions only
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module timer_counter16_cc_bench;
	import tmc_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, irq, ovf_evt, dma_ovf, seen;
	logic        ev_count, ev_dir, ev_restart, casc_in, quad_a, quad_b;
	logic [3:0]  cap_in, dma_cc;
	logic [7:0]  wo;
	logic [31:0] seed = 32'h0000_0031;
	logic [15:0] n, m, c, v, o0;
	logic [15:0] ovp = 16'h0000;
	logic [15:0] ccp = 16'h0000;
	int          fails = 0;
	int          checks = 0;
	int          cyc = 0;
	always #20 pclk = ~pclk;
	tmc_timer #(.NUM_CH(4), .FLT_LEN(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ev_count(ev_count), .ev_dir(ev_dir),
		.ev_restart(ev_restart), .casc_in(casc_in), .cap_in(cap_in), .quad_a(quad_a),
		.quad_b(quad_b), .irq(irq), .ovf_evt(ovf_evt), .dma_ovf(dma_ovf), .dma_cc(dma_cc),
		.wo(wo));
	tmc_evsrc #(.NUM_CH(4)) ev_u (.pclk(pclk), .ev_count(ev_count), .ev_dir(ev_dir),
		.ev_restart(ev_restart), .casc_in(casc_in), .cap_in(cap_in), .quad_a(quad_a),
		.quad_b(quad_b));
	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : xs
	function automatic logic [31:0] ctrl(tmc_clk_type k, tmc_cap_type p, logic [31:0] b);
		return b | {24'h0, p, 3'h0, k};
	endfunction : ctrl
	task tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails = fails + 1;
			tally_and_finish;
		end
	end
	// pulse outputs stand one cycle, so count them as they pass
	always @(posedge pclk)
	begin
		if (ovf_evt === 1'b1)
			ovp <= ovp + 16'h0001;
		if (dma_cc[1] === 1'b1)
			ccp <= ccp + 16'h0001;
	end
	task chk16(input string nm, input logic [15:0] x, input logic [15:0] g);
		checks++;
		if (g !== x)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk16
	task chk1(input string nm, input logic x, input logic g);
		checks++;
		if (g !== x)
		begin
			fails++;
			$display("[ERR] %s expected %b seen %b", nm, x, g);
		end
	endtask : chk1
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rdchk(input string nm, input logic [7:0] a, input logic [15:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk16(nm, x, r[15:0]);
	endtask : rdchk
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("per", `TMC_A_PER, `TMC_PER_RST);
		rdchk("peract", `TMC_A_PERACT, `TMC_PER_RST);
		rdchk("ctrl", `TMC_A_CTRL, 16'h0000);
		rdchk("cnt", `TMC_A_CNT, 16'h0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk1("slverr", 1'b1, e);
		chk16("unmapped", 16'h0000, r[15:0]);
		apb(1'b1, 8'h02, 32'h0000_0005);
		chk1("slverr_unaligned", 1'b1, e);
		$display("test registers done");
		c = xs();
		wr(`TMC_A_PER, 32'h0000_0010);
		rdchk("peract_held", `TMC_A_PERACT, `TMC_PER_RST);
		wr(`TMC_A_CC0, {16'h0, c});
		rdchk("cc0_held", `TMC_A_CC0, 16'h0000);
		wr(`TMC_A_CNT, 32'h0000_fffd);
		wr(`TMC_A_MASK, 32'h0000_0001);
		wr(`TMC_A_CTRL, ctrl(CLK_DIV1, CAP_OFF, 32'h0));
		seen = 1'b0;
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
		begin
			@(posedge pclk);
			seen = seen | (dma_ovf === 1'b1);
		end
		chk1("irq_ovf", 1'b1, irq);
		chk1("dma_ovf", 1'b1, seen);
		wr(`TMC_A_CTRL, 32'h0000_0000);
		rdchk("peract_new", `TMC_A_PERACT, 16'h0010);
		rdchk("cc0_new", `TMC_A_CC0, c);
		rdchk("stat_ovf", `TMC_A_STAT, 16'h0001);
		wr(`TMC_A_STAT, 32'h0000_0001);
		rdchk("stat_clr", `TMC_A_STAT, 16'h0000);
		repeat (2) @(posedge pclk);
		chk1("irq_clr", 1'b0, irq);
		$display("test overflow done");
		// stay at or below the active top of 0x10 so no wrap intrudes
		n = 16'd12 + (xs() % 16'd5);
		m = n >> 2;
		wr(`TMC_A_CNT, 32'h0000_0000);
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_OFF, 32'h0000_1800));
		ev_u.pulses(n, xs() % 4);
		rdchk("cnt_ev", `TMC_A_CNT, n);
		ev_u.set_dir(1'b1);
		ev_u.pulses(m, 0);
		rdchk("cnt_evdir", `TMC_A_CNT, n - m);
		ev_u.set_dir(1'b0);
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_OFF, 32'h0000_1100));
		ev_u.pulses(m, 1);
		rdchk("cnt_down", `TMC_A_CNT, n - m - m);
		ev_u.restart();
		rdchk("cnt_restart", `TMC_A_CNT, 16'h0010);
		$display("test events done");
		n = 16'd3 + (xs() % 16'd14);
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_INPUT, 32'h0001_0000));
		wr(`TMC_A_CNT, 32'h0000_0000);
		ev_u.pulses(n, 1);
		ev_u.set_cap(0, 1'b1);
		rdchk("cc0_cap", `TMC_A_CC0, n);
		rdchk("stat_cap", `TMC_A_STAT, 16'h0004);
		chk1("irq_masked", 1'b0, irq);
		ev_u.set_cap(0, 1'b0);
		ev_u.set_cap(0, 1'b1);
		rdchk("stat_err", `TMC_A_STAT, 16'h0006);
		wr(`TMC_A_MASK, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		chk1("irq_cap", 1'b1, irq);
		ev_u.set_cap(0, 1'b0);
		wr(`TMC_A_STAT, 32'h0000_00ff);
		$display("test capture done");
		wr(`TMC_A_CTRL, ctrl(CLK_QUAD, CAP_OFF, 32'h0));
		wr(`TMC_A_CNT, 32'h0000_0000);
		ev_u.quad(4);
		rdchk("cnt_quad", `TMC_A_CNT, 16'h0004);
		$display("test quadrature done");
		v = 16'd3 + (xs() % 16'd8);
		o0 = ovp;
		wr(`TMC_A_CC0 + 8'h04, {16'h0, v});
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_OFF, 32'h0002_0020));
		wr(`TMC_A_CNT, 32'h0000_0010);
		ev_u.pulses(1, 1);
		rdchk("cc1_new", `TMC_A_CC0 + 8'h04, v);
		ev_u.pulses(2, 1);
		chk1("wo_ss_on", 1'b1, wo[1]);
		ev_u.pulses(10, 1);
		chk1("wo_ss_off", 1'b0, wo[1]);
		chk16("dma_cc1", 16'h0001, ccp);
		chk16("ovf_evt", o0 + 16'h0001, ovp);
		rdchk("stat_cmp", `TMC_A_STAT, 16'h0009);
		$display("test compare done");
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_OFF, 32'h0000_0030));
		wr(`TMC_A_CNT, 32'h0000_000e);
		ev_u.pulses(4, 0);
		rdchk("cnt_ds", `TMC_A_CNT, 16'h000e);
		o0 = ovp;
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_OFF, 32'h0000_0400));
		wr(`TMC_A_CNT, 32'h0000_000f);
		ev_u.carry(3);
		rdchk("cnt_casc", `TMC_A_CNT, 16'h0001);
		chk16("casc_out", o0 + 16'h0001, ovp);
		wr(`TMC_A_CTRL, ctrl(CLK_EVENT, CAP_OFF, 32'h0002_0200));
		wr(`TMC_A_CNT, 32'h0000_0000);
		ev_u.pulses(3, 1);
		rdchk("cnt_split", `TMC_A_CNT, 16'h0003);
		chk1("wo_split_lo", 16'd3 < v, wo[1]);
		chk1("wo_split_hi", 1'b0, wo[5]);
		$display("test modes done");
		tally_and_finish;
	end
endmodule : timer_counter16_cc_bench
`default_nettype wire
